// ===== brc_byte_master.sv
`timescale 1ns/1ps
module brc_byte_master (
  // Clock
  input wire logic clk_sys_in,
  // Strobes toward the core
  output logic bus_start_out,
  output logic ptr_load_out,
  output logic [7:0] ptr_data_out,
  output logic wr_ack_out,
  output logic [7:0] wr_data_out,
  output logic rd_req_out,
  // Read answer
  input wire logic [7:0] rd_data_in,
  input wire logic rd_valid_in
);
  initial begin
    {bus_start_out, ptr_load_out, wr_ack_out, rd_req_out} = 4'h0;
    ptr_data_out = 8'h5a;
    wr_data_out = 8'ha5;
  end
  // Kind 0 START, 1 pointer, 2 write, 3 read; strobes idle a cycle between calls.
  task automatic op(input int kind, input logic [7:0] v, output logic [7:0] d,
                    output logic ok);
    @(posedge clk_sys_in);
    #1;
    bus_start_out = (kind == 0);
    ptr_load_out = (kind == 1);
    wr_ack_out = (kind == 2);
    rd_req_out = (kind == 3);
    ptr_data_out = v;
    wr_data_out = v;
    @(posedge clk_sys_in);
    #1;
    d = rd_data_in;
    ok = (rd_valid_in === (kind == 3));
    {bus_start_out, ptr_load_out, wr_ack_out, rd_req_out} = 4'h0;
    // Released data lines show the inverse so stale bytes cannot pass.
    ptr_data_out = ~v;
    wr_data_out = ~v;
  endtask : op
endmodule : brc_byte_master

// ===== brc_cal_step.sv
`timescale 1ns/1ps
module brc_cal_step (
  // Present and next calendar
  input wire logic [6:0][7:0] now_in,
  output logic [6:0][7:0] next_out
);
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      return {v[7:4] + 4'h1, 4'h0};
    end
    return {v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_inc

  function automatic logic is_leap(input logic [7:0] y);
    if (y[4]) begin
      return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end
    return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
  endfunction : is_leap

  function automatic logic [7:0] last_date(input logic [7:0] m, input logic [7:0] y);
    case (m)
      brc_pkg::MONTH_FEB: return is_leap(y) ? brc_pkg::DAYS_29 : brc_pkg::DAYS_28;
      brc_pkg::MONTH_APR, brc_pkg::MONTH_JUN,
      brc_pkg::MONTH_SEP, brc_pkg::MONTH_NOV: return brc_pkg::DAYS_30;
      default: return brc_pkg::DAYS_31;
    endcase
  endfunction : last_date

  always_comb begin
    logic c_min;
    logic c_hr;
    logic c_day;
    logic c_mon;
    logic c_yr;
    logic pm;
    logic [7:0] v;
    c_min = 1'b0;
    c_hr = 1'b0;
    c_day = 1'b0;
    c_mon = 1'b0;
    c_yr = 1'b0;
    pm = 1'b0;
    v = '0;
    next_out = now_in;
    v = now_in[brc_pkg::ADDR_SEC] & brc_pkg::MASK_MIN;
    c_min = (v == brc_pkg::BCD_59);
    next_out[brc_pkg::ADDR_SEC] = c_min ? brc_pkg::BCD_00 : bcd_inc(v);
    if (c_min) begin
      v = now_in[brc_pkg::ADDR_MIN];
      c_hr = (v == brc_pkg::BCD_59);
      next_out[brc_pkg::ADDR_MIN] = c_hr ? brc_pkg::BCD_00 : bcd_inc(v);
    end
    if (c_hr) begin
      v = now_in[brc_pkg::ADDR_HOUR];
      pm = v[brc_pkg::HOUR_PM_BIT];
      if (v[brc_pkg::HOUR_MODE12_BIT]) begin
        v = {3'h0, v[4:0]};
        if (v == brc_pkg::BCD_12) begin
          v = brc_pkg::BCD_01;
        end else if (v == brc_pkg::BCD_11) begin
          v = brc_pkg::BCD_12;
          c_day = pm;
          pm = ~pm;
        end else begin
          v = bcd_inc(v);
        end
        next_out[brc_pkg::ADDR_HOUR] = {2'b01, pm, v[4:0]};
      end else begin
        c_day = (v == brc_pkg::BCD_23);
        next_out[brc_pkg::ADDR_HOUR] = c_day ? brc_pkg::BCD_00 : bcd_inc(v);
      end
    end
    if (c_day) begin
      v = now_in[brc_pkg::ADDR_WDAY];
      next_out[brc_pkg::ADDR_WDAY] = (v == brc_pkg::WDAY_LAST) ? brc_pkg::BCD_01 : bcd_inc(v);
      v = now_in[brc_pkg::ADDR_DATE];
      c_mon = (v == last_date(now_in[brc_pkg::ADDR_MONTH], now_in[brc_pkg::ADDR_YEAR]));
      next_out[brc_pkg::ADDR_DATE] = c_mon ? brc_pkg::BCD_01 : bcd_inc(v);
    end
    if (c_mon) begin
      v = now_in[brc_pkg::ADDR_MONTH];
      c_yr = (v == brc_pkg::BCD_12);
      next_out[brc_pkg::ADDR_MONTH] = c_yr ? brc_pkg::BCD_01 : bcd_inc(v);
    end
    if (c_yr) begin
      v = now_in[brc_pkg::ADDR_YEAR];
      next_out[brc_pkg::ADDR_YEAR] = (v == brc_pkg::BCD_99) ? brc_pkg::BCD_00 : bcd_inc(v);
    end
  end
endmodule : brc_cal_step

// ===== brc_osc_div.sv
`timescale 1ns/1ps
module brc_osc_div (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Oscillator and control
  input wire logic osc_in,
  input wire logic halt_in,
  input wire logic clear_in,
  // Tick and wave taps
  output logic tick_out,
  output logic [3:0] taps_out
);
  typedef struct packed {
    logic [2:0] sync;
    logic level;
    logic [brc_pkg::DIV_WIDTH-1:0] div;
  } brc_div_state_t;

  brc_div_state_t cur;
  brc_div_state_t next_cur;
  logic rise;

  always_comb begin
    next_cur = cur;
    next_cur.sync = {cur.sync[1:0], osc_in};
    // A change counts only once the second and third stage agree.
    if (cur.sync[1] == cur.sync[2]) begin
      next_cur.level = cur.sync[2];
    end
    rise = next_cur.level & ~cur.level;
    tick_out = 1'b0;
    if (clear_in) begin
      next_cur.div = '0;
    end else if (rise && !halt_in) begin
      next_cur.div = cur.div + 1'b1;
      tick_out = (cur.div == brc_pkg::DIV_LAST);
    end
  end

  assign taps_out = {cur.level & ~halt_in, cur.div[brc_pkg::TAP_8K],
                     cur.div[brc_pkg::TAP_4K], cur.div[brc_pkg::TAP_1HZ]};

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end
endmodule : brc_osc_div

// ===== brc_pkg.sv
// Behaviour
// - Registers at 00h-07h, general RAM at 08h-3Fh, one byte space.
// - Pointer past 3Fh wraps to 00h during multibyte access.
// - Time and date held in BCD, tens digit in upper bits.
// - Weekday increments at midnight, cycling 01 to 07.
// - Seconds bit 7 set halts oscillator and timekeeping; clear runs it.
// - Power-up time 01/01/00 weekday 01 00:00:00 with halt set.
// - Hours bit 6 selects 12-hour (1) or 24-hour (0) counting.
// - Hours bit 5 is PM flag in 12-hour, tens bit in 24-hour.
// - Time copied into shadow buffers on every START; reads use them.
// - Writing seconds clears the sub-second divider chain.
// - Written byte commits at its acknowledge.
// - Unused bits of timekeeping and control registers read as 0.
// - Square wave off: pin follows control bit 7, powers up 0.
// - Control bit 4 set outputs the square wave, powers up 0.
// - Control bits 1:0 select 1Hz, 4.096kHz, 8.192kHz or 32.768kHz.
// - Rate select bits power up as 1.
// - At 1Hz, time advances on the falling edge of the wave.
// - Month end adjusted for short months, February with leap year.
// - Pointer loaded by first written byte, increments after each data byte.
package brc_pkg;
  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_SEC = 6'h00;
  localparam logic [5:0] ADDR_MIN = 6'h01;
  localparam logic [5:0] ADDR_HOUR = 6'h02;
  localparam logic [5:0] ADDR_WDAY = 6'h03;
  localparam logic [5:0] ADDR_DATE = 6'h04;
  localparam logic [5:0] ADDR_MONTH = 6'h05;
  localparam logic [5:0] ADDR_YEAR = 6'h06;
  localparam logic [5:0] ADDR_CTRL = 6'h07;
  localparam logic [5:0] ADDR_RAM_FIRST = 6'h08;
  localparam logic [5:0] ADDR_RAM_LAST = 6'h3f;
  localparam int TIME_REGS = 7;
  localparam int RAM_BYTES = 56;

  // ----------------------------------------------------------------
  // Writable bits per register
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_SEC = 8'hff;
  localparam logic [7:0] MASK_MIN = 8'h7f;
  localparam logic [7:0] MASK_HOUR = 8'h7f;
  localparam logic [7:0] MASK_WDAY = 8'h07;
  localparam logic [7:0] MASK_DATE = 8'h3f;
  localparam logic [7:0] MASK_MONTH = 8'h1f;
  localparam logic [7:0] MASK_YEAR = 8'hff;
  localparam logic [7:0] MASK_CTRL = 8'h93;

  // ----------------------------------------------------------------
  // Power-up values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_SEC = 8'h80;
  localparam logic [7:0] RST_MIN = 8'h00;
  localparam logic [7:0] RST_HOUR = 8'h00;
  localparam logic [7:0] RST_WDAY = 8'h01;
  localparam logic [7:0] RST_DATE = 8'h01;
  localparam logic [7:0] RST_MONTH = 8'h01;
  localparam logic [7:0] RST_YEAR = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h03;
  localparam logic [7:0] RST_RAM = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SEC_HALT_BIT = 7;
  localparam int HOUR_MODE12_BIT = 6;
  localparam int HOUR_PM_BIT = 5;
  localparam int CTRL_LEVEL_BIT = 7;
  localparam int CTRL_ON_BIT = 4;

  // ----------------------------------------------------------------
  // Calendar limits in BCD
  // ----------------------------------------------------------------
  localparam logic [7:0] BCD_59 = 8'h59;
  localparam logic [7:0] BCD_23 = 8'h23;
  localparam logic [7:0] BCD_12 = 8'h12;
  localparam logic [7:0] BCD_11 = 8'h11;
  localparam logic [7:0] BCD_01 = 8'h01;
  localparam logic [7:0] BCD_00 = 8'h00;
  localparam logic [7:0] BCD_99 = 8'h99;
  localparam logic [7:0] WDAY_LAST = 8'h07;
  localparam logic [7:0] DAYS_31 = 8'h31;
  localparam logic [7:0] DAYS_30 = 8'h30;
  localparam logic [7:0] DAYS_29 = 8'h29;
  localparam logic [7:0] DAYS_28 = 8'h28;
  localparam logic [7:0] MONTH_FEB = 8'h02;
  localparam logic [7:0] MONTH_APR = 8'h04;
  localparam logic [7:0] MONTH_JUN = 8'h06;
  localparam logic [7:0] MONTH_SEP = 8'h09;
  localparam logic [7:0] MONTH_NOV = 8'h11;

  // ----------------------------------------------------------------
  // Oscillator divider
  // ----------------------------------------------------------------
  localparam int DIV_WIDTH = 15;
  localparam logic [14:0] DIV_LAST = 15'h7fff;
  localparam int TAP_1HZ = 14;
  localparam int TAP_4K = 2;
  localparam int TAP_8K = 1;

  typedef enum logic [1:0] {
    RATE_1HZ = 2'b00,
    RATE_4K = 2'b01,
    RATE_8K = 2'b10,
    RATE_32K = 2'b11
  } brc_rate_t;
endpackage : brc_pkg

// ===== brc_rtc_core.sv
`timescale 1ns/1ps
module brc_rtc_core (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Oscillator
  input wire logic osc_in,
  // Byte access from the serial slave
  input wire logic bus_start_in,
  input wire logic ptr_load_in,
  input wire logic [7:0] ptr_data_in,
  input wire logic wr_ack_in,
  input wire logic [7:0] wr_data_in,
  input wire logic rd_req_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  // Open-drain square wave pin
  output logic square_wave_pin_out,
  output logic square_wave_pin_oe_out
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [brc_pkg::TIME_REGS-1:0][7:0] tm;
    logic [brc_pkg::TIME_REGS-1:0][7:0] shadow;
    logic [7:0] ctrl;
    logic [brc_pkg::RAM_BYTES-1:0][7:0] ram;
    logic [5:0] ptr;
    logic [7:0] rd_data;
    logic rd_valid;
    logic pin_oe;
  } brc_core_state_t;

  brc_core_state_t cur;
  brc_core_state_t next_cur;
  logic tick;
  logic [3:0] taps;
  logic [6:0][7:0] stepped;
  logic sec_write;
  logic level;

  function automatic logic [7:0] reg_mask(input logic [5:0] a);
    case (a)
      brc_pkg::ADDR_SEC: return brc_pkg::MASK_SEC;
      brc_pkg::ADDR_MIN: return brc_pkg::MASK_MIN;
      brc_pkg::ADDR_HOUR: return brc_pkg::MASK_HOUR;
      brc_pkg::ADDR_WDAY: return brc_pkg::MASK_WDAY;
      brc_pkg::ADDR_DATE: return brc_pkg::MASK_DATE;
      brc_pkg::ADDR_MONTH: return brc_pkg::MASK_MONTH;
      brc_pkg::ADDR_YEAR: return brc_pkg::MASK_YEAR;
      brc_pkg::ADDR_CTRL: return brc_pkg::MASK_CTRL;
      default: return 8'hff;
    endcase
  endfunction : reg_mask

  // ----------------------------------------------------------------
  // Divider and calendar
  // ----------------------------------------------------------------
  // seconds write clears chain
  assign sec_write = wr_ack_in && !ptr_load_in && (cur.ptr == brc_pkg::ADDR_SEC);

  brc_osc_div u_div (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .osc_in(osc_in),
    .halt_in(cur.tm[brc_pkg::ADDR_SEC][brc_pkg::SEC_HALT_BIT]),
    .clear_in(sec_write),
    .tick_out(tick),
    .taps_out(taps)
  );

  brc_cal_step u_step (
    .now_in(cur.tm),
    .next_out(stepped)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [5:0] a;
    a = cur.ptr;
    next_cur = cur;
    next_cur.rd_valid = 1'b0;
    if (tick) begin
      next_cur.tm = stepped;
    end
    if (bus_start_in) begin
      next_cur.shadow = next_cur.tm;
    end
    if (ptr_load_in) begin
      next_cur.ptr = ptr_data_in[5:0];
    end else if (wr_ack_in) begin
      if (a < brc_pkg::ADDR_CTRL) begin
        next_cur.tm[a[2:0]] = wr_data_in & reg_mask(a);
      end else if (a == brc_pkg::ADDR_CTRL) begin
        next_cur.ctrl = wr_data_in & brc_pkg::MASK_CTRL;
      end else begin
        next_cur.ram[a - brc_pkg::ADDR_RAM_FIRST] = wr_data_in;
      end
      next_cur.ptr = a + 6'h01;
    end else if (rd_req_in) begin
      if (a < brc_pkg::ADDR_CTRL) begin
        next_cur.rd_data = cur.shadow[a[2:0]];
      end else if (a == brc_pkg::ADDR_CTRL) begin
        next_cur.rd_data = cur.ctrl;
      end else begin
        next_cur.rd_data = cur.ram[a - brc_pkg::ADDR_RAM_FIRST];
      end
      next_cur.rd_valid = 1'b1;
      next_cur.ptr = a + 6'h01;
    end
    if (cur.ctrl[brc_pkg::CTRL_ON_BIT]) begin
      case (brc_pkg::brc_rate_t'(cur.ctrl[1:0]))
        brc_pkg::RATE_1HZ: level = taps[0];
        brc_pkg::RATE_4K: level = taps[1];
        brc_pkg::RATE_8K: level = taps[2];
        brc_pkg::RATE_32K: level = taps[3];
        default: level = 1'b0;
      endcase
    end else begin
      level = cur.ctrl[brc_pkg::CTRL_LEVEL_BIT];
    end
    // Open drain: the pin is pulled low only when the level is 0.
    next_cur.pin_oe = ~level;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cur.tm[brc_pkg::ADDR_SEC] <= brc_pkg::RST_SEC;
      cur.tm[brc_pkg::ADDR_MIN] <= brc_pkg::RST_MIN;
      cur.tm[brc_pkg::ADDR_HOUR] <= brc_pkg::RST_HOUR;
      cur.tm[brc_pkg::ADDR_WDAY] <= brc_pkg::RST_WDAY;
      cur.tm[brc_pkg::ADDR_DATE] <= brc_pkg::RST_DATE;
      cur.tm[brc_pkg::ADDR_MONTH] <= brc_pkg::RST_MONTH;
      cur.tm[brc_pkg::ADDR_YEAR] <= brc_pkg::RST_YEAR;
      cur.shadow <= '0;
      cur.ctrl <= brc_pkg::RST_CTRL;
      cur.ram <= '0;
      cur.ptr <= brc_pkg::ADDR_SEC;
      cur.rd_data <= '0;
      cur.rd_valid <= 1'b0;
      cur.pin_oe <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  assign rd_data_out = cur.rd_data;
  assign rd_valid_out = cur.rd_valid;
  assign square_wave_pin_out = 1'b0;
  assign square_wave_pin_oe_out = cur.pin_oe;
endmodule : brc_rtc_core

// ===== brc_rtc_core_properties.sv
`timescale 1ns/1ps
module brc_rtc_core_properties (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Watched ports
  input wire logic osc_in,
  input wire logic bus_start_in,
  input wire logic ptr_load_in,
  input wire logic [7:0] ptr_data_in,
  input wire logic wr_ack_in,
  input wire logic [7:0] wr_data_in,
  input wire logic rd_req_in,
  input wire logic [7:0] rd_data_out,
  input wire logic rd_valid_out,
  input wire logic square_wave_pin_out,
  input wire logic square_wave_pin_oe_out
);
  // --------------------------------------------------------------
  // Mirror of pointer, RAM and control
  // --------------------------------------------------------------
  // Time bytes are left out because their shadow needs the oscillator; the halt bit is kept.
  logic [5:0] ptr;
  logic halt;
  logic [7:0] mem [64];
  logic [7:0] ctrl;
  logic [7:0] exp_q;
  logic rd_take;
  assign rd_take = rd_req_in && !ptr_load_in && !wr_ack_in;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ptr <= 6'h00;
      halt <= 1'b1;
      ctrl <= brc_pkg::RST_CTRL;
      exp_q <= 8'h00;
      for (int i = 0; i < 64; i++) begin
        mem[i] <= 8'h00;
      end
    end else if (ptr_load_in) begin
      ptr <= ptr_data_in[5:0];
    end else if (wr_ack_in) begin
      ptr <= ptr + 6'h01;
      mem[ptr] <= wr_data_in;
      if (ptr == brc_pkg::ADDR_SEC) begin
        halt <= wr_data_in[brc_pkg::SEC_HALT_BIT];
      end
      if (ptr == brc_pkg::ADDR_CTRL) begin
        ctrl <= wr_data_in & brc_pkg::MASK_CTRL;
      end
    end else if (rd_req_in) begin
      ptr <= ptr + 6'h01;
      exp_q <= (ptr == brc_pkg::ADDR_CTRL) ? ctrl : mem[ptr];
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  a_read_answer: assert property (rd_take |=> rd_valid_out)
    else $error("read request got no answer");
  a_valid_cause: assert property (rd_valid_out |-> $past(rd_take))
    else $error("read answer without request");
  a_ram_readback: assert property (rd_valid_out && $past(ptr) >= 6'h08 |-> rd_data_out == exp_q)
    else $error("ram byte read back wrong");
  a_ctrl_readback: assert property (rd_valid_out && $past(ptr) == 6'h07 |-> rd_data_out == exp_q)
    else $error("control byte read back wrong");
  a_unused_zero: assert property (rd_valid_out && $past(ptr) inside {[6'h01:6'h05]}
    |-> !rd_data_out[7])
    else $error("unused time bit read as one");
  a_pin_low_only: assert property (square_wave_pin_out == 1'b0)
    else $error("open drain pin driven high");
  a_level_follow: assert property (!ctrl[4] && ctrl == $past(ctrl)
    |-> square_wave_pin_oe_out == !ctrl[7])
    else $error("pin level differs from control");
  // A halt that lands inside the window stops the fast wave, so it excuses the pin.
  a_fast_wave: assert property (ctrl == 8'h13 && !halt && $rose(osc_in)
    |-> ##[2:6] (!square_wave_pin_oe_out || halt))
    else $error("fast wave does not follow oscillator");
endmodule : brc_rtc_core_properties

bind brc_rtc_core brc_rtc_core_properties u_props (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .osc_in(osc_in),
  .bus_start_in(bus_start_in), .ptr_load_in(ptr_load_in), .ptr_data_in(ptr_data_in),
  .wr_ack_in(wr_ack_in), .wr_data_in(wr_data_in), .rd_req_in(rd_req_in),
  .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
  .square_wave_pin_out(square_wave_pin_out), .square_wave_pin_oe_out(square_wave_pin_oe_out));

// ===== brc_rtc_core_test.sv
`timescale 1ns/1ps
module brc_rtc_core_test;
  localparam int WATCH_NS = 1000000;
  logic clk, rst_n, osc, bs, pl, wa, rq, rv, pin, oe, ok, prev;
  logic [7:0] pd, wd, rdd, d;
  logic [7:0] ram_q [56];
  logic [7:0] wr_t [7] = '{8'hb4, 8'h72, 8'hfd, 8'hc9, 8'he2, 8'h24, 8'hec};
  logic [7:0] ex_t [7] = '{8'h34, 8'h72, 8'h05, 8'h09, 8'h02, 8'h24, 8'h80};
  logic [7:0] pw_t [8] = '{8'h80, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h03};
  int fails, comparisons, n, e;
  int unsigned rnd;
  brc_rtc_core uut (.clk_sys_in(clk), .rst_n_in(rst_n), .osc_in(osc), .bus_start_in(bs),
    .ptr_load_in(pl), .ptr_data_in(pd), .wr_ack_in(wa), .wr_data_in(wd), .rd_req_in(rq),
    .rd_data_out(rdd), .rd_valid_out(rv), .square_wave_pin_out(pin),
    .square_wave_pin_oe_out(oe));
  brc_byte_master bm (.clk_sys_in(clk), .bus_start_out(bs), .ptr_load_out(pl),
    .ptr_data_out(pd), .wr_ack_out(wa), .wr_data_out(wd), .rd_req_out(rq),
    .rd_data_in(rdd), .rd_valid_in(rv));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    osc = 1'b0;
    #3.3;
    forever #62.5 osc = ~osc;
  end
  // Oscillator is 12.5 clocks: 2000 clocks hold 320 of its toggles, halved per divider stage.
  // The 1 Hz tap never toggles within such a window.
  function automatic int wave_toggles(input int rate);
    return (rate == 0) ? 0 : (rate == 3) ? 320 : (160 >> (3 - rate));
  endfunction : wave_toggles
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic rd(input logic [7:0] exp);
    bm.op(3, 8'h00, d, ok);
    check({7'h00, ok}, 8'h01);
    check(d, exp);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    bm.op(1, a, d, ok);
    bm.op(2, v, d, ok);
  endtask : wr
  task automatic close_out();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  initial begin
    #(WATCH_NS);
    fails++;
    close_out();
  end
  initial begin
    rst_n = 1'b0;
    rnd = $urandom(32'h39a4621f);
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    bm.op(1, 8'h00, d, ok);
    bm.op(0, 8'h00, d, ok);
    for (int i = 0; i < 8; i++) rd(pw_t[i]);
    check({7'h00, oe}, 8'h01);
    check({7'h00, pin}, 8'h00);
    bm.op(1, 8'h08, d, ok);
    for (int i = 0; i < 56; i++) begin
      ram_q[i] = 8'($urandom);
      bm.op(2, ram_q[i], d, ok);
    end
    // The pointer has wrapped, so these land on the time bytes and control.
    bm.op(2, 8'h92, d, ok);
    for (int i = 0; i < 7; i++) bm.op(2, wr_t[i], d, ok);
    // The pin register follows a new control byte one clock after the byte lands.
    @(posedge clk);
    #1;
    check({7'h00, oe}, 8'h00);
    bm.op(1, 8'h00, d, ok);
    rd(8'h80);
    bm.op(0, 8'h00, d, ok);
    bm.op(1, 8'h3e, d, ok);
    rd(ram_q[54]);
    rd(ram_q[55]);
    rd(8'h92);
    for (int i = 0; i < 7; i++) rd(ex_t[i]);
    wr(8'h00, 8'h00);
    for (int r = 0; r < 5; r++) begin
      if (r == 4) wr(8'h00, 8'h80);
      wr(8'h07, 8'h10 | 8'(r > 3 ? 3 : r));
      repeat (10) @(posedge clk);
      #1;
      prev = oe;
      n = 0;
      repeat (2000) begin
        @(posedge clk);
        #1;
        if (oe !== prev) n++;
        prev = oe;
      end
      e = (r > 3) ? 0 : wave_toggles(r);
      comparisons++;
      // Window phase against the wave moves the count by up to two either way.
      if (n < e - 2 || n > e + 2) begin
        fails++;
        $display("[FAIL] %0t got %h expected %h", $time, n, e);
      end
    end
    bm.op(0, 8'h00, d, ok);
    bm.op(1, 8'h00, d, ok);
    rd(8'h80);
    close_out();
  end
endmodule : brc_rtc_core_test
